//--- pkg/lpm_pkg.sv
// lpm_pkg: register map, field layout, reset values and timing for the bus phy / analog mux control block.
// assumes a 32-bit apb slave with byte addresses, one aligned word per register.
package lpm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets; printed ones are word indexes, the *_ADDR names their byte address
    localparam logic [7:0] SYS_CTRL_OFS     = 8'h00;
    localparam logic [7:0] SYS_STAT_OFS     = 8'h04;
    localparam logic [7:0] IRQ_MASK_OFS     = 8'h0c;
    localparam logic [7:0] MUX_CTRL_OFS     = 8'h08;
    localparam logic [7:0] MUX_CTRL_ADDR    = 8'h20;
    localparam logic [7:0] RST_CAUSE_OFS    = 8'h0d;
    localparam logic [7:0] RST_CAUSE_ADDR   = 8'h34;
    localparam logic [7:0] IRQ_FLAG_OFS     = 8'h10;
    localparam logic [7:0] MODE_OFS         = 8'h14;

    ////////////////////////////////////////////////////////////////////////
    // system control fields
    localparam int SC_PS_ON_BIT = 0;
    localparam int SC_SLEW_LSB  = 1;
    localparam logic [1:0] SLEW_10K   = 2'h0;
    localparam logic [1:0] SLEW_20K   = 2'h1;
    localparam logic [1:0] SLEW_FAST1 = 2'h2;
    localparam logic [1:0] SLEW_FAST2 = 2'h3;
    localparam logic [1:0] SLEW_RESET = SLEW_20K;
    // status / irq fields
    localparam int ST_CUR_LIM_BIT  = 0;
    localparam int IM_BUS_IE_BIT   = 5;
    localparam int IF_BUS_IF_BIT   = 0;

    // mux control fields
    localparam int MC_CS_ON_BIT    = 7;
    localparam int MC_LEVEL_LSB    = 5;
    localparam int MC_GAIN_BIT     = 4;
    localparam int MC_SEL_LSB      = 0;
    localparam logic [7:0] MUX_CTRL_RESET = 8'h00;

    // reset cause fields
    localparam int RC_OVERTEMP_BIT = 4;
    localparam int RC_UNDERV_BIT   = 3;
    localparam int RC_BUS_WAKE_BIT = 1;
    localparam int RC_PIN_WAKE_BIT = 0;

    // mux source codes
    localparam logic [3:0] SEL_ANALOG_IN   = 4'ha;
    localparam logic [3:0] SEL_CAL_PIN     = 4'hb;
    localparam logic [3:0] SEL_LAST_USED   = 4'hc;
    localparam logic [3:0] SEL_UNUSED_A    = 4'h7;

    // power modes
    localparam logic [1:0] MODE_RUN   = 2'h0;
    localparam logic [1:0] MODE_STOP  = 2'h1;
    localparam logic [1:0] MODE_SLEEP = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ             = 250;
    localparam int WAKE_DOM_US         = 30;
    localparam int WAKE_DOM_CYC        = WAKE_DOM_US * CLK_MHZ;
    localparam int CUR_LIM_US          = 10;
    localparam int CUR_LIM_CYC         = CUR_LIM_US * CLK_MHZ;

    typedef enum logic [2:0]
    {
        WK_IDLE = 3'b001,
        WK_LOW  = 3'b010,
        WK_ARM  = 3'b100
    } lpm_wake_t;

endpackage : lpm_pkg

//--- hdl/lpm_top.sv
// lpm_top: bus transceiver control, low-power wake detection, reset cause flags and analog mux control.
// assumes apb master on REF_CLK_IN, pins already synchronous, analog comparators arrive as levels.
//
// Function
// R1: two-bit slew select, resets to 20 kbit/s
// R2: overtemp flag set by event, one clears
// R3: undervoltage flag set by event, one clears
// R4: bus wake flag set on bus wake
// R5: wake pin flag set on pin wake
// R6: transmitter enabled only with power stage on
// R7: current limit sets flag, later disables transceiver
// R8: transmit low drives bus dominant
// R9: transmit idles high, bus recessive
// R10: receive output follows bus level
// R11: low power: transmitter off, pull-up off
// R12: stop mode bus wake sets irq flag; here only while the bus irq enable is set
// R13: sleep mode bus wake triggers reset, flag
// R14: current source needs power, select, enable
// R15: two-bit level selects source magnitude
// R16: current source halted in stop, sleep
// R17: four-bit select routes twelve mux sources
// R18: gain bit one low, zero high
// R19: mux control register layout, all zero reset
// R20: source codes map to sense channels
// R21: bus irq enable gates cpu request
// R22: reset cause bits 4,3,1,0; bit2 zero
// R23: zero writes ignored, flags stay set
module lpm_top #(
    parameter int WAKE_DOM_CYC = lpm_pkg::WAKE_DOM_CYC,
    parameter int CUR_LIM_CYC  = lpm_pkg::CUR_LIM_CYC
) (
    input  wire logic        REF_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        TX_DATA_IN,
    output logic             RX_DATA_OUT,
    input  wire logic        BUS_LEVEL_IN,
    output logic             BUS_DRIVE_LOW_OUT,
    output logic             BUS_PULLUP_ON_OUT,
    output logic             BUS_WEAK_SRC_ON_OUT,
    output logic [1:0]       SLEW_RATE_SELECT_OUT,
    input  wire logic        CUR_LIMIT_IN,
    input  wire logic        OVERTEMP_IN,
    input  wire logic        UNDERVOLT_IN,
    input  wire logic        WAKE_INPUT_PIN_IN,
    output logic             BUS_IRQ_OUT,
    output logic             WAKE_RESET_OUT,
    output logic             CUR_SRC_ON_OUT,
    output logic [1:0]       CUR_LEVEL_OUT,
    output logic             SENSE_GAIN_LOW_OUT,
    output logic [3:0]       MUX_SELECT_OUT,
    output logic             MUX_VALID_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic        ps_on_reg;
    logic [1:0]  slew_reg;
    logic        bus_ie_reg;
    logic        bus_if_reg;
    logic        cur_lim_flag_reg;
    logic        xcvr_off_reg;
    logic [7:0]  mux_ctrl_reg;
    logic        ot_flag_reg;
    logic        uv_flag_reg;
    logic        bw_flag_reg;
    logic        pw_flag_reg;
    logic [1:0]  mode_reg;
    logic [31:0] lim_cnt_reg;
    logic [31:0] dom_cnt_reg;
    logic        pin_store_reg;
    logic        bus_prev_reg;
    lpm_pkg::lpm_wake_t wake_reg;

    logic        wr_acc;
    logic        rd_acc;
    logic        low_power;
    logic        bus_wake;
    logic        pin_wake;
    logic        mapped;
    logic [31:0] rd_next;

    // apb access strobes; zero-wait slave: writes act in the access phase, read data is captured in the setup phase
    assign wr_acc    = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign rd_acc    = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
    assign low_power = (mode_reg == lpm_pkg::MODE_STOP) || (mode_reg == lpm_pkg::MODE_SLEEP);

    ////////////////////////////////////////////////////////////////////////
    // system control and irq mask
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            ps_on_reg  <= 1'b0;
            slew_reg   <= lpm_pkg::SLEW_RESET;  // R1
            bus_ie_reg <= 1'b0;                 // R21
            mode_reg   <= lpm_pkg::MODE_RUN;
        end
        else if (wr_acc)
        begin
            if (PADDR_IN == lpm_pkg::SYS_CTRL_OFS)
            begin
                ps_on_reg <= PWDATA_IN[lpm_pkg::SC_PS_ON_BIT];
                slew_reg  <= PWDATA_IN[lpm_pkg::SC_SLEW_LSB +: 2];  // R1
            end
            if (PADDR_IN == lpm_pkg::IRQ_MASK_OFS)
                bus_ie_reg <= PWDATA_IN[lpm_pkg::IM_BUS_IE_BIT];
            if (PADDR_IN == lpm_pkg::MODE_OFS)
                mode_reg <= PWDATA_IN[1:0];
        end
        else if (bus_wake || pin_wake)
            mode_reg <= lpm_pkg::MODE_RUN;  // any wake returns to run
    end

    // mux control register, all fields read/write
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            mux_ctrl_reg <= lpm_pkg::MUX_CTRL_RESET;  // R19
        else if (wr_acc && PADDR_IN == lpm_pkg::MUX_CTRL_ADDR)
            mux_ctrl_reg <= PWDATA_IN[7:0];  // R19
    end

    ////////////////////////////////////////////////////////////////////////
    // current limit: flag at once, shut the transceiver after the delay
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            lim_cnt_reg      <= 32'h0000_0000;
            cur_lim_flag_reg <= 1'b0;
            xcvr_off_reg     <= 1'b0;
        end
        else
        begin
            if (CUR_LIMIT_IN && !xcvr_off_reg)
                lim_cnt_reg <= lim_cnt_reg + 32'h0000_0001;
            else if (!CUR_LIMIT_IN)
                lim_cnt_reg <= 32'h0000_0000;
            // set wins over the write-one clear
            if (CUR_LIMIT_IN)
                cur_lim_flag_reg <= 1'b1;  // R7
            else if (wr_acc && PADDR_IN == lpm_pkg::SYS_STAT_OFS && PWDATA_IN[lpm_pkg::ST_CUR_LIM_BIT])
                cur_lim_flag_reg <= 1'b0;
            if (lim_cnt_reg >= 32'(CUR_LIM_CYC - 1) && CUR_LIMIT_IN)
                xcvr_off_reg <= 1'b1;  // R7
            else if (!ps_on_reg)
                xcvr_off_reg <= 1'b0;  // re-arm by cycling power stage enable
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus wake detector: dominant longer than wake time, then rising edge
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            wake_reg     <= lpm_pkg::WK_IDLE;
            dom_cnt_reg  <= 32'h0000_0000;
            bus_prev_reg <= 1'b1;
        end
        else
        begin
            bus_prev_reg <= BUS_LEVEL_IN;
            unique case (wake_reg)
                lpm_pkg::WK_IDLE:
                begin
                    dom_cnt_reg <= 32'h0000_0000;
                    if (low_power && !BUS_LEVEL_IN)
                        wake_reg <= lpm_pkg::WK_LOW;
                end
                lpm_pkg::WK_LOW:
                begin
                    dom_cnt_reg <= dom_cnt_reg + 32'h0000_0001;
                    if (!low_power || BUS_LEVEL_IN)
                        wake_reg <= lpm_pkg::WK_IDLE;  // too short a pulse is ignored
                    else if (dom_cnt_reg >= 32'(WAKE_DOM_CYC - 1))
                        wake_reg <= lpm_pkg::WK_ARM;
                end
                lpm_pkg::WK_ARM:
                begin
                    if (!low_power || BUS_LEVEL_IN)
                        wake_reg <= lpm_pkg::WK_IDLE;
                end
                default:
                    wake_reg <= lpm_pkg::WK_IDLE;
            endcase
        end
    end

    // wake fires on the rising edge that ends a long dominant phase
    assign bus_wake = (wake_reg == lpm_pkg::WK_ARM) && low_power && BUS_LEVEL_IN && !bus_prev_reg;
    assign pin_wake = low_power && (WAKE_INPUT_PIN_IN != pin_store_reg);

    // wake pin state stored while running, compared while asleep
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            pin_store_reg <= 1'b0;
        else if (!low_power)
            pin_store_reg <= WAKE_INPUT_PIN_IN;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus irq flag and reset cause flags; set wins over write-one clear, zero writes ignored
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            bus_if_reg <= 1'b0;
        else if (bus_wake && mode_reg == lpm_pkg::MODE_STOP && bus_ie_reg)
            bus_if_reg <= 1'b1;  // R12
        else if (wr_acc && PADDR_IN == lpm_pkg::IRQ_FLAG_OFS && PWDATA_IN[lpm_pkg::IF_BUS_IF_BIT])
            bus_if_reg <= 1'b0;
    end

    // cause flags survive RST_IN only via power-on in a real die; here RST_IN is power-on
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            ot_flag_reg <= 1'b0;
            uv_flag_reg <= 1'b0;
            bw_flag_reg <= 1'b0;
            pw_flag_reg <= 1'b0;
        end
        else
        begin
            if (OVERTEMP_IN)
                ot_flag_reg <= 1'b1;  // R2
            else if (wr_acc && PADDR_IN == lpm_pkg::RST_CAUSE_ADDR && PWDATA_IN[lpm_pkg::RC_OVERTEMP_BIT])
                ot_flag_reg <= 1'b0;  // R23
            if (UNDERVOLT_IN)
                uv_flag_reg <= 1'b1;  // R3
            else if (wr_acc && PADDR_IN == lpm_pkg::RST_CAUSE_ADDR && PWDATA_IN[lpm_pkg::RC_UNDERV_BIT])
                uv_flag_reg <= 1'b0;  // R23
            if (bus_wake && mode_reg == lpm_pkg::MODE_SLEEP)
                bw_flag_reg <= 1'b1;  // R4 R13
            else if (wr_acc && PADDR_IN == lpm_pkg::RST_CAUSE_ADDR && PWDATA_IN[lpm_pkg::RC_BUS_WAKE_BIT])
                bw_flag_reg <= 1'b0;  // R23
            if (pin_wake && mode_reg == lpm_pkg::MODE_SLEEP)
                pw_flag_reg <= 1'b1;  // R5
            else if (wr_acc && PADDR_IN == lpm_pkg::RST_CAUSE_ADDR && PWDATA_IN[lpm_pkg::RC_PIN_WAKE_BIT])
                pw_flag_reg <= 1'b0;  // R23
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin and analog outputs, all registered
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            RX_DATA_OUT          <= 1'b1;
            BUS_DRIVE_LOW_OUT    <= 1'b0;
            BUS_PULLUP_ON_OUT    <= 1'b0;
            BUS_WEAK_SRC_ON_OUT  <= 1'b1;
            SLEW_RATE_SELECT_OUT <= lpm_pkg::SLEW_RESET;
            BUS_IRQ_OUT          <= 1'b0;
            WAKE_RESET_OUT       <= 1'b0;
            CUR_SRC_ON_OUT       <= 1'b0;
            CUR_LEVEL_OUT        <= 2'h0;
            SENSE_GAIN_LOW_OUT   <= 1'b0;
            MUX_SELECT_OUT       <= 4'h0;
            MUX_VALID_OUT        <= 1'b1;
        end
        else
        begin
            RX_DATA_OUT          <= BUS_LEVEL_IN;  // R10
            // a high or undriven transmit input (pad pull-up) leaves the bus recessive
            BUS_DRIVE_LOW_OUT    <= !TX_DATA_IN && ps_on_reg && !xcvr_off_reg && !low_power;  // R6 R8 R9 R11
            BUS_PULLUP_ON_OUT    <= !low_power;  // R11
            BUS_WEAK_SRC_ON_OUT  <= low_power;   // R11
            SLEW_RATE_SELECT_OUT <= slew_reg;    // R1
            BUS_IRQ_OUT          <= bus_if_reg && bus_ie_reg;  // R21 R12
            WAKE_RESET_OUT       <= bus_wake && mode_reg == lpm_pkg::MODE_SLEEP;  // R13
            CUR_SRC_ON_OUT       <= ps_on_reg && mux_ctrl_reg[lpm_pkg::MC_CS_ON_BIT] && !low_power &&
                                    (mux_ctrl_reg[3:0] == lpm_pkg::SEL_ANALOG_IN ||
                                     mux_ctrl_reg[3:0] == lpm_pkg::SEL_CAL_PIN);  // R14 R16
            CUR_LEVEL_OUT        <= mux_ctrl_reg[lpm_pkg::MC_LEVEL_LSB +: 2];  // R15
            SENSE_GAIN_LOW_OUT   <= mux_ctrl_reg[lpm_pkg::MC_GAIN_BIT];        // R18
            MUX_SELECT_OUT       <= mux_ctrl_reg[lpm_pkg::MC_SEL_LSB +: 4];    // R17 R20
            MUX_VALID_OUT        <= mux_ctrl_reg[3:0] != lpm_pkg::SEL_UNUSED_A &&
                                    mux_ctrl_reg[3:0] <= lpm_pkg::SEL_LAST_USED;  // R20
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb
    begin
        rd_next = 32'h0000_0000;
        mapped  = 1'b1;
        unique case (PADDR_IN)
            lpm_pkg::SYS_CTRL_OFS:   rd_next = {29'h0, slew_reg, ps_on_reg};
            lpm_pkg::SYS_STAT_OFS:   rd_next = {31'h0, cur_lim_flag_reg};
            lpm_pkg::MUX_CTRL_ADDR:  rd_next = {24'h0, mux_ctrl_reg};
            lpm_pkg::IRQ_MASK_OFS:   rd_next = {26'h0, bus_ie_reg, 5'h00};
            lpm_pkg::IRQ_FLAG_OFS:   rd_next = {31'h0, bus_if_reg};
            lpm_pkg::MODE_OFS:       rd_next = {30'h0, mode_reg};
            lpm_pkg::RST_CAUSE_ADDR: rd_next = {27'h0, ot_flag_reg, uv_flag_reg, 1'b0, bw_flag_reg, pw_flag_reg};  // R22
            default:                 mapped  = 1'b0;
        endcase
    end

    // data captured in setup, ready in access: one wait-free transfer
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            PRDATA_OUT  <= 32'h0000_0000;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end
        else
        begin
            PREADY_OUT  <= PSEL_IN && !PENABLE_IN;
            PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !mapped;
            if (rd_acc)
                PRDATA_OUT <= rd_next;
        end
    end

endmodule : lpm_top

//--- verif/lpm_monitor.sv
// lpm_monitor: port-level checks on the bus phy / analog mux control block.
// assumes single clock REF_CLK_IN, synchronous active-high RST_IN, bound to lpm_top.
module lpm_monitor (
    input wire logic       REF_CLK_IN,
    input wire logic       RST_IN,
    input wire logic       PSEL_IN,
    input wire logic       PENABLE_IN,
    input wire logic       TX_DATA_IN,
    input wire logic       BUS_LEVEL_IN,
    input wire logic       RX_DATA_OUT,
    input wire logic       PREADY_OUT,
    input wire logic       PSLVERR_OUT,
    input wire logic       BUS_DRIVE_LOW_OUT,
    input wire logic       BUS_PULLUP_ON_OUT,
    input wire logic       BUS_WEAK_SRC_ON_OUT,
    input wire logic       WAKE_RESET_OUT,
    input wire logic       CUR_SRC_ON_OUT,
    input wire logic [3:0] MUX_SELECT_OUT,
    input wire logic       MUX_VALID_OUT
);
    default clocking mon_cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    ////////////////////////////////////////////////////////////////////////
    // apb answer: zero wait states, error only inside an access
    apb_ready_a: assert property ((PSEL_IN && !PENABLE_IN) |=> PREADY_OUT && PENABLE_IN)
        else $error("ready missing after setup");
    apb_err_a: assert property (PSLVERR_OUT |-> PREADY_OUT && PSEL_IN && PENABLE_IN)
        else $error("slave error outside access");
    // transmit path; drive is registered from the pin one cycle back
    tx_drive_a: assert property (BUS_DRIVE_LOW_OUT |-> !$past(TX_DATA_IN))
        else $error("bus driven while transmit high");
    rx_follow_a: assert property (!$past(RST_IN) |-> RX_DATA_OUT == $past(BUS_LEVEL_IN))
        else $error("receive not following bus");
    // low power: weak source replaces pull-up, transmitter off
    pullup_swap_a: assert property (BUS_PULLUP_ON_OUT != BUS_WEAK_SRC_ON_OUT)
        else $error("pull-up and weak source overlap");
    lp_tx_off_a: assert property (BUS_WEAK_SRC_ON_OUT |-> !BUS_DRIVE_LOW_OUT)
        else $error("transmitter on in low power");
    // current source only on a routed pin and in run mode
    cur_src_gate_a: assert property (CUR_SRC_ON_OUT |-> BUS_PULLUP_ON_OUT &&
        (MUX_SELECT_OUT == lpm_pkg::SEL_ANALOG_IN || MUX_SELECT_OUT == lpm_pkg::SEL_CAL_PIN))
        else $error("current source on without gating");
    mux_valid_a: assert property (MUX_VALID_OUT == (MUX_SELECT_OUT <= lpm_pkg::SEL_LAST_USED
        && MUX_SELECT_OUT != lpm_pkg::SEL_UNUSED_A))
        else $error("mux valid wrong for select");
    // wake reset is a single pulse following a recessive sample
    wake_pulse_a: assert property (WAKE_RESET_OUT |->
        ($past(BUS_LEVEL_IN) || $past(BUS_LEVEL_IN, 2)) ##1 !WAKE_RESET_OUT)
        else $error("wake reset pulse malformed");
endmodule : lpm_monitor

bind lpm_top lpm_monitor lpm_monitor_i (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .TX_DATA_IN(TX_DATA_IN), .BUS_LEVEL_IN(BUS_LEVEL_IN),
    .RX_DATA_OUT(RX_DATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .BUS_DRIVE_LOW_OUT(BUS_DRIVE_LOW_OUT), .BUS_PULLUP_ON_OUT(BUS_PULLUP_ON_OUT),
    .BUS_WEAK_SRC_ON_OUT(BUS_WEAK_SRC_ON_OUT), .WAKE_RESET_OUT(WAKE_RESET_OUT),
    .CUR_SRC_ON_OUT(CUR_SRC_ON_OUT), .MUX_SELECT_OUT(MUX_SELECT_OUT), .MUX_VALID_OUT(MUX_VALID_OUT));

//--- verif/lpm_bus_model.sv
// lpm_bus_model: single-wire bus as a wired-and of the block's driver and another node.
// assumes the block's pull-up and weak source are the only sources of recessive level.
module lpm_bus_model (
    input  wire logic drive_low_in,
    input  wire logic other_dom_in,
    input  wire logic pullup_on_in,
    input  wire logic weak_on_in,
    output logic      level_out
);
    // no source at all reads low: an unpowered line floats to ground
    assign level_out = !(drive_low_in || other_dom_in) && (pullup_on_in || weak_on_in);
endmodule : lpm_bus_model

//--- verif/lpm_tb.sv
// tb: self-checking bench for lpm_top over apb, bus pins and mux outputs.
// assumes lpm_pkg compiled first and lpm_monitor bound to the design.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, psel, pen, pwr, tx, cl, ot, uv, wk, dom, got;
    logic        rdy, err, rx, lvl, drv, pu, wsrc, irq, wrst, cs, gain, mv;
    logic [1:0]  slew, lev;
    logic [3:0]  sel;
    logic [7:0]  pa, seed, v;
    logic [31:0] pwd, prd;
    logic [32:0] e;
    logic [32:0] exp_q[$];
    int          n_mismatch, check_count, i;

    lpm_top #(.WAKE_DOM_CYC(8), .CUR_LIM_CYC(8)) lpm_top_i (.REF_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
        .PREADY_OUT(rdy), .PSLVERR_OUT(err), .TX_DATA_IN(tx), .RX_DATA_OUT(rx), .BUS_LEVEL_IN(lvl),
        .BUS_DRIVE_LOW_OUT(drv), .BUS_PULLUP_ON_OUT(pu), .BUS_WEAK_SRC_ON_OUT(wsrc),
        .SLEW_RATE_SELECT_OUT(slew), .CUR_LIMIT_IN(cl), .OVERTEMP_IN(ot), .UNDERVOLT_IN(uv),
        .WAKE_INPUT_PIN_IN(wk), .BUS_IRQ_OUT(irq), .WAKE_RESET_OUT(wrst), .CUR_SRC_ON_OUT(cs),
        .CUR_LEVEL_OUT(lev), .SENSE_GAIN_LOW_OUT(gain), .MUX_SELECT_OUT(sel), .MUX_VALID_OUT(mv));
    lpm_bus_model lpm_bus_model_i (.drive_low_in(drv), .other_dom_in(dom), .pullup_on_in(pu),
        .weak_on_in(wsrc), .level_out(lvl));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    // one apb transfer; trailing idle lets registered outputs settle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // no assumed wait count: only the watchdog ends a hang here
        do
            @(posedge clk);
        while (rdy !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        step(3);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ex = 1'b0);
        exp_q.push_back({ex, x});
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic finish_test();
        // a read whose answer never came is a failure too
        if (exp_q.size() != 0)
            n_mismatch++;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog; run needs well under ten microseconds
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #40000;
        n_mismatch++;
        finish_test();
    end
    // read checker: oldest note against data taken at the ready edge
    always @(posedge clk)
        if (psel && pen && !pwr && rdy === 1'b1)
        begin
            e = exp_q.pop_front();
            chk("prdata", e[31:0], prd);
            chk("pslverr", {31'h0, e[32]}, err);
        end

    initial
    begin
        {psel, pen, pwr, cl, ot, uv, wk, dom} = 8'h00;
        {pa, pwd} = 40'h0;
        tx = 1'b1;
        rst = 1'b1;
        seed = 8'h07;
        step(5);
        rst <= 1'b0;
        step(1);
        // reset values and an unmapped place
        chk("slew", lpm_pkg::SLEW_RESET, slew);
        rd(lpm_pkg::SYS_CTRL_OFS, 32'h2);
        rd(lpm_pkg::MUX_CTRL_ADDR, 32'h0);
        rd(lpm_pkg::RST_CAUSE_ADDR, 32'h0);
        rd(8'h40, 32'h0, 1'b1);
        for (i = 0; i < 4; i++)
        begin
            wr(lpm_pkg::SYS_CTRL_OFS, {29'h0, i[1:0], 1'b1});
            chk("slew", 32'(i), slew);
        end
        // mux fields, random and one routed source
        for (i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            v = (i == 0) ? 8'h8a : seed;
            wr(lpm_pkg::MUX_CTRL_ADDR, {24'h0, v});
            rd(lpm_pkg::MUX_CTRL_ADDR, {24'h0, v});
            chk("valid", v[3:0] != 4'h7 && v[3:0] <= 4'hc, mv);
            chk("level", v[6:5], lev);
            chk("gain", v[4], gain);
            chk("select", v[3:0], sel);
            chk("src", v[7] && (v[3:0] == lpm_pkg::SEL_ANALOG_IN || v[3:0] == lpm_pkg::SEL_CAL_PIN), cs);
        end
        wr(lpm_pkg::MUX_CTRL_ADDR, 32'h8b);
        tx <= 1'b0;
        step(3);
        chk("drive", 1'b1, drv);
        chk("rx", 1'b0, rx);
        chk("src", 1'b1, cs);
        wr(lpm_pkg::SYS_CTRL_OFS, 32'h2);
        chk("drive", 1'b0, drv);
        chk("src", 1'b0, cs);
        wr(lpm_pkg::SYS_CTRL_OFS, 32'h3);
        tx <= 1'b1;
        step(3);
        chk("drive", 1'b0, drv);
        chk("rx", 1'b1, rx);
        // current limit held past the shutdown delay
        tx <= 1'b0;
        cl <= 1'b1;
        step(16);
        chk("drive", 1'b0, drv);
        cl <= 1'b0;
        tx <= 1'b1;
        rd(lpm_pkg::SYS_STAT_OFS, 32'h1);
        wr(lpm_pkg::SYS_STAT_OFS, 32'h1);
        rd(lpm_pkg::SYS_STAT_OFS, 32'h0);
        wr(lpm_pkg::SYS_CTRL_OFS, 32'h2);
        wr(lpm_pkg::SYS_CTRL_OFS, 32'h3);
        // reset cause flags: zero writes leave them
        ot <= 1'b1;
        uv <= 1'b1;
        step(2);
        ot <= 1'b0;
        uv <= 1'b0;
        rd(lpm_pkg::RST_CAUSE_ADDR, 32'h18);
        wr(lpm_pkg::RST_CAUSE_ADDR, 32'h0);
        rd(lpm_pkg::RST_CAUSE_ADDR, 32'h18);
        wr(lpm_pkg::RST_CAUSE_ADDR, 32'h10);
        rd(lpm_pkg::RST_CAUSE_ADDR, 32'h08);
        wr(lpm_pkg::RST_CAUSE_ADDR, 32'h08);
        rd(lpm_pkg::RST_CAUSE_ADDR, 32'h0);
        // sleep: weak source, source halted, bus wake reset
        wr(lpm_pkg::MODE_OFS, {30'h0, lpm_pkg::MODE_SLEEP});
        tx <= 1'b0;
        step(2);
        chk("pullup", 1'b0, pu);
        chk("weak", 1'b1, wsrc);
        chk("drive", 1'b0, drv);
        chk("src", 1'b0, cs);
        dom <= 1'b1;
        step(14);
        dom <= 1'b0;
        tx <= 1'b1;
        got = 1'b0;
        repeat (40)
        begin
            @(posedge clk);
            if (wrst === 1'b1) got = 1'b1;
        end
        chk("wake_reset", 1'b1, got);
        rd(lpm_pkg::RST_CAUSE_ADDR, 32'h2);
        wr(lpm_pkg::RST_CAUSE_ADDR, 32'h2);
        rd(lpm_pkg::RST_CAUSE_ADDR, 32'h0);
        // stop: bus irq flag, enable gating, clear
        wr(lpm_pkg::IRQ_MASK_OFS, 32'h20);
        wr(lpm_pkg::MODE_OFS, {30'h0, lpm_pkg::MODE_STOP});
        dom <= 1'b1;
        step(14);
        dom <= 1'b0;
        step(6);
        chk("irq", 1'b1, irq);
        rd(lpm_pkg::IRQ_FLAG_OFS, 32'h1);
        wr(lpm_pkg::IRQ_MASK_OFS, 32'h0);
        chk("irq", 1'b0, irq);
        wr(lpm_pkg::IRQ_MASK_OFS, 32'h20);
        chk("irq", 1'b1, irq);
        wr(lpm_pkg::IRQ_FLAG_OFS, 32'h1);
        chk("irq", 1'b0, irq);
        // pin wake in sleep
        wr(lpm_pkg::MODE_OFS, {30'h0, lpm_pkg::MODE_SLEEP});
        wk <= 1'b1;
        step(8);
        rd(lpm_pkg::RST_CAUSE_ADDR, 32'h1);
        finish_test();
    end
endmodule : tb
